// >>> rtl/cwd_top.sv
// Operation
// (RULE1) Programmed bit reads 0, erased bit reads 1; options follow read values.
// (RULE2) Option word sits at location 2007h, outside user program space.
// (RULE3) Range 2000h-3FFFh is reachable only in programming mode.
// (RULE4) Protect selector is repeated pairs in bits 13-8 and 5-4.
// (RULE5) 2K memory: 11 off, 10 400h-7FFh, 01 200h-7FFh, 00 all.
// (RULE6) 1K memory: 11 and 10 off, 01 200h-3FFh, 00 all.
// (RULE7) Half-K memory: only 00 protects 000h-1FFh.
// (RULE8) Programmer writes the same value into every protect pair.
// (RULE9) Bit 7 is unimplemented and reads as zero.
// (RULE10) Bit 6 set enables brown-out reset.
// (RULE11) Bit 3 is active low power-up delay enable.
// (RULE12) Bit 2 set enables the watchdog.
// (RULE13) Bits 1:0 select RC, high-speed, standard or low-power crystal mode.
// (RULE14) Brown-out enable forces the power-up delay on.
// (RULE15) An erased part has the power-up delay off; here erased bit 6 enables brown-out, which forces the delay on.
// (RULE16) Power-up delay holds reset 72 ms, only on power-up; here it also runs again after brown-out release.
// (RULE17) Start-up timer holds reset until the crystal is stable.
// (RULE18) Brown-out resets the device and holds reset at least 72 ms.
// (RULE19) Watchdog runs from its own RC oscillator, gated by option bits.
// (RULE20) Sleep ends on external reset, watchdog wake or interrupt.
// (RULE21) Crystal modes accept an external clock on the input pin.
// (RULE22) Start-up timer counts 1024 input edges after the delay, crystal modes only.
// (RULE23) RC mode drives oscillator frequency divided by four on the output pin.
// (RULE24) Options are captured at reset and held constant in operation.
// (RULE25) Disagreeing protect pairs leave memory unprotected.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
module cwd_top #(
  parameter int PROG_WORDS = cwd_pkg::CWD_WORDS_2K,
  parameter int POWERUP_DELAY_TIMER_CYCLES = cwd_pkg::CWD_POWERUP_DELAY_TIMER_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Nonvolatile option cells and programming port
  input wire logic [13:0] nv_word,
  input wire logic prog_mode,
  output logic nv_prog_strobe,
  output logic [13:0] nv_prog_data,
  // Register port
  input wire logic [13:0] reg_addr,
  input wire logic [13:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [13:0] reg_rdata,
  // Reset and wake sources
  input wire logic brownout_detect,
  input wire logic ext_reset_req,
  input wire logic watchdog_wake,
  input wire logic irq_wake,
  // Oscillator pins
  input wire logic osc_input_pin,
  output logic osc_output_pin,
  // Decoded options
  output logic brownout_reset_enable,
  output logic powerup_delay_on,
  output logic watchdog_rc_enable,
  output logic [1:0] osc_mode,
  output logic protect_enable,
  output logic [10:0] protect_lo,
  output logic [10:0] protect_hi,
  // Core control
  output logic core_reset,
  output logic core_sleep
);
  import cwd_pkg::*;

  initial begin
    if (PROG_WORDS != CWD_WORDS_HALFK && PROG_WORDS != CWD_WORDS_1K &&
        PROG_WORDS != CWD_WORDS_2K) begin
      $error("PROG_WORDS must be 512, 1024 or 2048");
    end
    if (POWERUP_DELAY_TIMER_CYCLES < 1 || POWERUP_DELAY_TIMER_CYCLES >= (1 << CWD_CNT_W)) begin
      $error("POWERUP_DELAY_TIMER_CYCLES out of counter range");
    end
  end

  localparam logic [CWD_CNT_W-1:0] POWERUP_DELAY_TIMER_LAST = CWD_CNT_W'(POWERUP_DELAY_TIMER_CYCLES - 1);
  localparam logic [CWD_CNT_W-1:0] OST_LAST = CWD_CNT_W'(CWD_OST_EDGES - 1);

  typedef struct packed {
    cwd_phase_t phase;
    logic [CWD_CNT_W-1:0] cnt;
    logic osc_prev;
    logic [1:0] osc_div;
    logic osc_out;
    logic bor_en;
    logic powerup_delay_timer_en;
    logic wdt_en;
    logic [1:0] osc;
    logic prot_en;
    logic [10:0] prot_lo;
    logic [10:0] prot_hi;
    logic core_rst;
    logic sleep;
    logic [13:0] rdata;
    logic prog_strobe;
    logic [13:0] prog_data;
  } cwd_state_t;

  localparam cwd_state_t RESET_STATE = '{
    phase: CWD_LOAD,
    cnt: '0,
    osc_prev: 1'b0,
    osc_div: 2'h0,
    osc_out: 1'b0,
    bor_en: 1'b0,
    powerup_delay_timer_en: 1'b0,
    wdt_en: 1'b0,
    osc: CWD_OSC_RC,
    prot_en: 1'b0,
    prot_lo: CWD_ADDR_ZERO,
    prot_hi: CWD_ADDR_ZERO,
    core_rst: 1'b1,
    sleep: 1'b0,
    rdata: 14'h0000,
    prog_strobe: 1'b0,
    prog_data: 14'h0000
  };

  cwd_state_t s_q;
  cwd_state_t s_d;

  // Protection decode; lo/hi only meaningful when enable is set
  function automatic logic [22:0] cwd_protect(input logic [13:0] w);
    logic [1:0] sel;
    logic agree;
    logic en;
    logic [10:0] lo;
    logic [10:0] hi;
    sel = w[CWD_CP0_HI:CWD_CP0_LO]; // RULE4
    agree = (w[CWD_CP1_HI:CWD_CP1_LO] == sel) && (w[CWD_CP2_HI:CWD_CP2_LO] == sel) &&
            (w[CWD_CP3_HI:CWD_CP3_LO] == sel); // RULE8
    en = 1'b0;
    lo = CWD_ADDR_ZERO;
    hi = CWD_ADDR_ZERO;
    if (agree) begin // RULE25
      if (PROG_WORDS == CWD_WORDS_2K) begin // RULE5
        hi = CWD_END_2K;
        unique case (sel)
          CWD_CP_OFF: en = 1'b0;
          CWD_CP_UPPER: begin
            en = 1'b1;
            lo = CWD_ADDR_400;
          end
          CWD_CP_HALF: begin
            en = 1'b1;
            lo = CWD_ADDR_200;
          end
          CWD_CP_ALL: en = 1'b1;
        endcase
      end else if (PROG_WORDS == CWD_WORDS_1K) begin // RULE6
        hi = CWD_END_1K;
        if (sel == CWD_CP_HALF) begin
          en = 1'b1;
          lo = CWD_ADDR_200;
        end else if (sel == CWD_CP_ALL) begin
          en = 1'b1;
        end
      end else begin // RULE7
        hi = CWD_END_HALFK;
        en = (sel == CWD_CP_ALL);
      end
    end
    if (!en) begin
      hi = CWD_ADDR_ZERO;
    end
    return {en, lo, hi};
  endfunction : cwd_protect

  function automatic logic cwd_is_crystal(input logic [1:0] m);
    return m != CWD_OSC_RC; // RULE21
  endfunction : cwd_is_crystal

  logic osc_rise;
  logic in_special;
  logic [13:0] cfg_read;
  logic [22:0] prot_dec;
  logic word_powerup_delay_timer;

  assign osc_rise = osc_input_pin & ~s_q.osc_prev;
  assign in_special = (reg_addr >= CWD_SPECIAL_LO) && (reg_addr <= CWD_SPECIAL_HI);
  // Cells read straight through: programmed 0, erased 1
  assign cfg_read = nv_word & CWD_CFG_IMPL_MASK; // RULE1 RULE9
  assign prot_dec = cwd_protect(nv_word);
  // Erased part leaves bit 3 high, so delay stays off unless brown-out forces it
  assign word_powerup_delay_timer = ~nv_word[CWD_POWERUP_DELAY_TIMER_N_BIT] | nv_word[CWD_BOR_BIT]; // RULE11 RULE14 RULE15

  always_comb begin
    s_d = s_q;
    s_d.prog_strobe = 1'b0;
    s_d.rdata = 14'h0000;
    s_d.osc_prev = osc_input_pin;

    // Clock-out: divide input edges by four in RC mode only
    if (s_q.osc == CWD_OSC_RC) begin // RULE23
      if (osc_rise) begin
        s_d.osc_div = s_q.osc_div + 2'h1;
      end
      s_d.osc_out = s_d.osc_div[1];
    end else begin
      s_d.osc_div = 2'h0;
      s_d.osc_out = 1'b0;
    end

    unique case (s_q.phase)
      CWD_LOAD: begin
        // Options latched once after release, then frozen until next reset
        s_d.bor_en = nv_word[CWD_BOR_BIT]; // RULE24 RULE10
        s_d.powerup_delay_timer_en = word_powerup_delay_timer;
        s_d.wdt_en = nv_word[CWD_WDT_BIT]; // RULE12 RULE19
        s_d.osc = nv_word[CWD_OSC_HI:CWD_OSC_LO]; // RULE13
        s_d.prot_en = prot_dec[22];
        s_d.prot_lo = prot_dec[21:11];
        s_d.prot_hi = prot_dec[10:0];
        s_d.cnt = '0;
        if (word_powerup_delay_timer) begin
          s_d.phase = CWD_POWERUP_DELAY_TIMER;
        end else if (cwd_is_crystal(nv_word[CWD_OSC_HI:CWD_OSC_LO])) begin
          s_d.phase = CWD_OST;
        end else begin
          s_d.phase = CWD_RUN;
        end
      end
      CWD_BOR_HOLD: begin
        s_d.cnt = '0;
        if (!brownout_detect) begin
          s_d.phase = CWD_POWERUP_DELAY_TIMER; // RULE18
        end
      end
      CWD_POWERUP_DELAY_TIMER: begin
        if (s_q.cnt == POWERUP_DELAY_TIMER_LAST) begin // RULE16
          s_d.cnt = '0;
          s_d.phase = cwd_is_crystal(s_q.osc) ? CWD_OST : CWD_RUN;
        end else begin
          s_d.cnt = s_q.cnt + CWD_CNT_W'(1);
        end
      end
      CWD_OST: begin
        if (osc_rise) begin
          if (s_q.cnt == OST_LAST) begin // RULE17 RULE22
            s_d.cnt = '0;
            s_d.phase = CWD_RUN;
          end else begin
            s_d.cnt = s_q.cnt + CWD_CNT_W'(1);
          end
        end
      end
      CWD_RUN: begin
        if (reg_wr && !in_special && reg_addr == CWD_CTRL_ADDR &&
            reg_wdata[CWD_CTRL_SLEEP_BIT]) begin
          s_d.phase = CWD_SLEEP;
        end
      end
      CWD_SLEEP: begin
        // Watchdog wake counts only while the watchdog is enabled
        if ((watchdog_wake && s_q.wdt_en) || irq_wake) begin // RULE20
          s_d.cnt = '0;
          s_d.phase = cwd_is_crystal(s_q.osc) ? CWD_OST : CWD_RUN; // RULE22
        end
      end
      CWD_EXT_HOLD: begin
        // External reset gets no power-up delay or start-up count
        if (!ext_reset_req) begin
          s_d.phase = CWD_RUN;
        end
      end
    endcase

    // Brown-out outranks external reset and restarts the delay
    if (s_q.phase != CWD_LOAD) begin
      if (s_q.bor_en && brownout_detect) begin // RULE18
        s_d.phase = CWD_BOR_HOLD;
        s_d.cnt = '0;
      end else if (ext_reset_req && s_q.phase != CWD_BOR_HOLD) begin // RULE20
        s_d.phase = CWD_EXT_HOLD;
        s_d.cnt = '0;
      end
    end

    s_d.core_rst = !(s_d.phase == CWD_RUN || s_d.phase == CWD_SLEEP);
    s_d.sleep = (s_d.phase == CWD_SLEEP);

    // Register reads: special space answers only to the programmer
    if (reg_rd) begin
      if (in_special) begin
        if (prog_mode && reg_addr == CWD_CFG_ADDR) begin // RULE2 RULE3
          s_d.rdata = cfg_read;
        end
      end else if (reg_addr == CWD_STAT_ADDR) begin
        s_d.rdata = {5'h00, s_q.prot_en, s_q.osc, s_q.wdt_en, s_q.powerup_delay_timer_en,
                     s_q.bor_en, s_q.phase};
      end
    end

    // Programming can only clear cells; bit 7 is always written with its present cell value
    if (reg_wr && prog_mode && reg_addr == CWD_CFG_ADDR) begin // RULE3
      s_d.prog_strobe = 1'b1;
      s_d.prog_data = (reg_wdata | ~CWD_CFG_IMPL_MASK) & nv_word;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  assign nv_prog_strobe = s_q.prog_strobe;
  assign nv_prog_data = s_q.prog_data;
  assign reg_rdata = s_q.rdata;
  assign osc_output_pin = s_q.osc_out;
  assign brownout_reset_enable = s_q.bor_en;
  assign powerup_delay_on = s_q.powerup_delay_timer_en;
  assign watchdog_rc_enable = s_q.wdt_en;
  assign osc_mode = s_q.osc;
  assign protect_enable = s_q.prot_en;
  assign protect_lo = s_q.prot_lo;
  assign protect_hi = s_q.prot_hi;
  assign core_reset = s_q.core_rst;
  assign core_sleep = s_q.sleep;
endmodule : cwd_top

// >>> rtl/cwd_pkg.sv
package cwd_pkg;
  // Option word location and reachable special space
  localparam logic [13:0] CWD_CFG_ADDR = 14'h2007;
  localparam logic [13:0] CWD_SPECIAL_LO = 14'h2000;
  localparam logic [13:0] CWD_SPECIAL_HI = 14'h3fff;
  // Block status and control words
  localparam logic [13:0] CWD_STAT_ADDR = 14'h1f80;
  localparam logic [13:0] CWD_CTRL_ADDR = 14'h1f81;
  localparam int CWD_CTRL_SLEEP_BIT = 0;

  // Option word field positions
  localparam int CWD_CP3_HI = 13;
  localparam int CWD_CP3_LO = 12;
  localparam int CWD_CP2_HI = 11;
  localparam int CWD_CP2_LO = 10;
  localparam int CWD_CP1_HI = 9;
  localparam int CWD_CP1_LO = 8;
  localparam int CWD_UNIMPL_BIT = 7;
  localparam int CWD_BOR_BIT = 6;
  localparam int CWD_CP0_HI = 5;
  localparam int CWD_CP0_LO = 4;
  localparam int CWD_POWERUP_DELAY_TIMER_N_BIT = 3;
  localparam int CWD_WDT_BIT = 2;
  localparam int CWD_OSC_HI = 1;
  localparam int CWD_OSC_LO = 0;
  localparam logic [13:0] CWD_CFG_IMPL_MASK = 14'h3f7f;

  // Oscillator modes
  localparam logic [1:0] CWD_OSC_RC = 2'h3;
  localparam logic [1:0] CWD_OSC_HS = 2'h2;
  localparam logic [1:0] CWD_OSC_XT = 2'h1;
  localparam logic [1:0] CWD_OSC_LP = 2'h0;

  // Protect selector values
  localparam logic [1:0] CWD_CP_OFF = 2'h3;
  localparam logic [1:0] CWD_CP_UPPER = 2'h2;
  localparam logic [1:0] CWD_CP_HALF = 2'h1;
  localparam logic [1:0] CWD_CP_ALL = 2'h0;

  // Protected range bounds
  localparam logic [10:0] CWD_ADDR_ZERO = 11'h000;
  localparam logic [10:0] CWD_ADDR_200 = 11'h200;
  localparam logic [10:0] CWD_ADDR_400 = 11'h400;
  localparam logic [10:0] CWD_END_HALFK = 11'h1ff;
  localparam logic [10:0] CWD_END_1K = 11'h3ff;
  localparam logic [10:0] CWD_END_2K = 11'h7ff;
  localparam int CWD_WORDS_HALFK = 512;
  localparam int CWD_WORDS_1K = 1024;
  localparam int CWD_WORDS_2K = 2048;

  // Timing
  localparam int CWD_CLK_HZ = 10_000_000;
  localparam int CWD_POWERUP_DELAY_TIMER_MS = 72;
  localparam int CWD_POWERUP_DELAY_TIMER_CYCLES = CWD_POWERUP_DELAY_TIMER_MS * (CWD_CLK_HZ / 1000);
  localparam int CWD_OST_EDGES = 1024;
  localparam int CWD_CNT_W = 20;

  typedef enum logic [2:0] {
    CWD_LOAD,
    CWD_BOR_HOLD,
    CWD_POWERUP_DELAY_TIMER,
    CWD_OST,
    CWD_RUN,
    CWD_SLEEP,
    CWD_EXT_HOLD
  } cwd_phase_t;
endpackage : cwd_pkg

// >>> dv/cwd_osc_model.sv
`timescale 1ns/100ps
module cwd_osc_model #(
  parameter realtime HALF_NS = 155.0
) (
  // External clock source
  output logic osc_clk
);
  // Odd start offset keeps it out of phase with the core clock
  initial begin
    osc_clk = 1'b0;
    #37.3;
    forever #HALF_NS osc_clk = ~osc_clk;
  end
endmodule : cwd_osc_model

// >>> dv/cwd_top_properties.sv
`timescale 1ns/100ps
module cwd_props #(
  parameter int POWERUP_DELAY_TIMER_CYCLES = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Inputs
  input wire logic [13:0] nv_word,
  input wire logic prog_mode,
  input wire logic [13:0] reg_addr,
  input wire logic reg_rd,
  input wire logic irq_wake,
  // Outputs
  input wire logic [13:0] reg_rdata,
  input wire logic [1:0] osc_mode,
  input wire logic brownout_reset_enable,
  input wire logic powerup_delay_on,
  input wire logic watchdog_rc_enable,
  input wire logic protect_enable,
  input wire logic core_reset,
  input wire logic core_sleep
);
  import cwd_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [1:0] age_q;
  logic por_q;
  logic [19:0] hold_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      age_q <= 2'h0;
      por_q <= 1'b1;
      hold_q <= 20'h0;
    end else begin
      if (age_q != 2'h3) age_q <= age_q + 2'h1;
      if (!core_reset) por_q <= 1'b0;
      if (core_reset && hold_q != 20'hfffff) hold_q <= hold_q + 20'h1;
    end
  end
  bor_decode_a: assert property (age_q == 2'h3 |-> brownout_reset_enable == nv_word[6])
    else $error("brown-out enable mismatch");
  delay_decode_a: assert property (age_q == 2'h3 |->
    powerup_delay_on == (!nv_word[3] || nv_word[6]))
    else $error("power-up delay enable mismatch");
  wdt_decode_a: assert property (age_q == 2'h3 |-> watchdog_rc_enable == nv_word[2])
    else $error("watchdog enable mismatch");
  osc_decode_a: assert property (age_q == 2'h3 |-> osc_mode == nv_word[1:0])
    else $error("oscillator mode mismatch");
  // Assumes the 2K part that the bench instantiates
  protect_decode_a: assert property (age_q == 2'h3 |-> protect_enable ==
    (nv_word[13:8] == {3{nv_word[5:4]}} && nv_word[5:4] != 2'h3))
    else $error("protect enable mismatch");
  cfg_read_a: assert property ($past(reg_rd) && $past(prog_mode) && $past(reg_addr) == CWD_CFG_ADDR
    |-> reg_rdata == ($past(nv_word) & 14'h3f7f))
    else $error("option word read mismatch");
  special_lock_a: assert property ($past(reg_rd) && !$past(prog_mode) && $past(reg_addr) >= 14'h2000
    |-> reg_rdata == 14'h0)
    else $error("special space readable outside programming");
  powerup_delay_timer_hold_a: assert property ($fell(core_reset) && por_q && powerup_delay_on
    |-> hold_q >= POWERUP_DELAY_TIMER_CYCLES)
    else $error("power-up delay cut short");
  irq_wake_a: assert property (core_sleep && irq_wake |-> ##[1:4] !core_sleep)
    else $error("interrupt did not wake");
  cover property ($fell(core_sleep));
  cover property ($fell(core_reset) && por_q && powerup_delay_on);
  cover property (protect_enable);
endmodule : cwd_props
bind cwd_top cwd_props #(.POWERUP_DELAY_TIMER_CYCLES(POWERUP_DELAY_TIMER_CYCLES)) cwd_props_i (.clk, .reset, .nv_word,
  .prog_mode, .reg_addr, .reg_rd, .irq_wake, .reg_rdata, .osc_mode, .brownout_reset_enable,
  .powerup_delay_on, .watchdog_rc_enable, .protect_enable, .core_reset, .core_sleep);

// >>> dv/cwd_top_tb.sv
`timescale 1ns/100ps
module cwd_top_tb;
  import cwd_pkg::*;
  localparam int PW = 20;
  logic clk, reset, prog_mode, reg_wr, reg_rd, brownout_detect, ext_reset_req;
  logic watchdog_wake, irq_wake, osc_clk, nv_prog_strobe, osc_output_pin;
  logic [13:0] nv_word, reg_addr, reg_wdata, reg_rdata, nv_prog_data, d;
  logic brownout_reset_enable, powerup_delay_on, watchdog_rc_enable;
  logic protect_enable, core_reset, core_sleep;
  logic [1:0] osc_mode;
  logic [10:0] protect_lo, protect_hi;
  logic [14:0] ps;
  int error_cnt, cmp_count, n, t;
  cwd_top #(.POWERUP_DELAY_TIMER_CYCLES(PW)) cwd_top_i (.clk, .reset, .nv_word, .prog_mode, .nv_prog_strobe,
    .nv_prog_data, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .brownout_detect,
    .ext_reset_req, .watchdog_wake, .irq_wake, .osc_input_pin(osc_clk), .osc_output_pin,
    .brownout_reset_enable, .powerup_delay_on, .watchdog_rc_enable, .osc_mode,
    .protect_enable, .protect_lo, .protect_hi, .core_reset, .core_sleep);
  cwd_osc_model cwd_osc_model_i (.osc_clk);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task wr(input logic [13:0] a, input logic [13:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1 ps = {nv_prog_strobe, nv_prog_data};
    @(posedge clk);
  endtask : wr
  task rd(input logic [13:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk);
  endtask : rd
  function automatic logic [31:0] expo(input logic [13:0] w);
    logic [1:0] c;
    logic en;
    c = w[5:4];
    en = (w[13:8] == {3{c}}) && (c != 2'h3);
    return {4'h0, en, en ? (c == 2'h2 ? 11'h400 : c == 2'h1 ? 11'h200 : 11'h0) : 11'h0,
      en ? 11'h7ff : 11'h0, w[6], ~w[3] | w[6], w[2], w[1:0]};
  endfunction : expo
  task pu(input logic [13:0] w);
    int e;
    reset <= 1'b1;
    nv_word <= w;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk({4'h0, protect_enable, protect_lo, protect_hi, brownout_reset_enable,
      powerup_delay_on, watchdog_rc_enable, osc_mode}, expo(w));
    e = ((w[6] | ~w[3]) ? PW : 0) + ((w[1:0] != 2'h3) ? 3174 : 0);
    n = 0;
    while (core_reset === 1'b1 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, n >= e - 8 && n <= e + 8}, 32'h1);
    if (w[1:0] != 2'h3) chk({31'h0, osc_output_pin}, 32'h0);
    $display("power-up with word %h done", w);
  endtask : pu
  task t_regs(input logic [13:0] w);
    prog_mode <= 1'b1;
    rd(CWD_CFG_ADDR);
    chk({18'h0, d}, {18'h0, w & 14'h3f7f});
    rd(14'h0123);
    chk({18'h0, d}, 32'h0);
    wr(CWD_CFG_ADDR, 14'h2aaa);
    chk({17'h0, ps}, {18'h1, 14'h2aaa & w});
    prog_mode <= 1'b0;
    rd(CWD_CFG_ADDR);
    chk({18'h0, d}, 32'h0);
    wr(CWD_CFG_ADDR, 14'h2aaa);
    chk({31'h0, ps[14]}, 32'h0);
    $display("register access done");
  endtask : t_regs
  task t_bor;
    brownout_detect <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk({31'h0, core_reset}, 32'h1);
    @(posedge clk);
    brownout_detect <= 1'b0;
    n = 0;
    while (core_reset === 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, n >= PW && n <= PW + 4}, 32'h1);
    $display("brown-out done");
  endtask : t_bor
  task t_rc;
    t = 0;
    ps[0] = osc_output_pin;
    // 62 core cycles span 20 input periods, so about 10 output toggles
    repeat (62) begin
      @(posedge clk);
      #1 if (osc_output_pin !== ps[0]) t++;
      ps[0] = osc_output_pin;
    end
    chk({31'h0, t >= 9 && t <= 11}, 32'h1);
    $display("clock output done");
  endtask : t_rc
  task t_sleep(input logic [13:0] w);
    @(posedge clk);
    wr(CWD_CTRL_ADDR, 14'h0001);
    #1 chk({31'h0, core_sleep}, 32'h1);
    @(posedge clk);
    watchdog_wake <= 1'b1;
    repeat (4) @(posedge clk);
    watchdog_wake <= 1'b0;
    #1 chk({31'h0, core_sleep}, {31'h0, ~w[2]});
    @(posedge clk);
    irq_wake <= 1'b1;
    @(posedge clk);
    irq_wake <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk({31'h0, core_sleep}, 32'h0);
    $display("sleep and wake done");
  endtask : t_sleep
  task t_ext;
    // External reset skips delay and start-up count, so release is quick
    ext_reset_req <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk({31'h0, core_reset}, 32'h1);
    @(posedge clk);
    ext_reset_req <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk({31'h0, core_reset}, 32'h0);
    $display("external reset done");
  endtask : t_ext
  task wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    {reset, prog_mode, reg_wr, reg_rd, brownout_detect} = 5'h10;
    {ext_reset_req, watchdog_wake, irq_wake} = 3'h0;
    {nv_word, reg_addr, reg_wdata} = {14'h3fff, 14'h0, 14'h0};
    error_cnt = 0;
    cmp_count = 0;
    @(posedge clk);
    // Every oscillator mode and protect code, bit 7 cell left erased
    for (int i = 0; i < 4; i++) begin
      pu({i[1:0], i[1:0], i[1:0], 1'b1, i[0], i[1:0], i[1], ~i[0], i[1:0]});
      t_regs({i[1:0], i[1:0], i[1:0], 1'b1, i[0], i[1:0], i[1], ~i[0], i[1:0]});
    end
    pu(14'h1f7b);
    t_bor();
    t_rc();
    t_sleep(14'h1f7b);
    pu(14'h3fff);
    t_sleep(14'h3fff);
    t_ext();
    wrap_up();
  end
  initial begin
    #(100 * 40000);
    error_cnt++;
    wrap_up();
  end
endmodule : cwd_top_tb
